// ===== verilog/crf_top.v
// CAN receiver flag register, identifier mapping and arbitration helpers behind an APB slave.
`timescale 1ns/1ps
`default_nettype none
`include "crf_regs.vh"

// Notes on behaviour
// R1: In sleep with wake enable, bus activity sets the wake flag; unmasked it interrupts.
// R2: Error-counter-driven bus status change sets the status change flag; unmasked it interrupts.
// R3: State fields update only while no status change flag is pending.
// R4: Four-bit bus status: two-bit receiver field and two-bit transmitter field.
// R5: Receiver field: 00 below 96, 01 below 128, 10 above, 11 bus-off.
// R6: Outside init, writing one clears a flag, zero ignored; state fields read-only.
// R7: During init mode the wake and status change flags are held cleared and the flag register cannot be written.
// R8: State fields keep tracking the counters regardless of init mode.
// R9: Extended identifier is 29 bits and goes out most significant bit first.
// R10: The numerically smallest identifier wins arbitration.
// R11: Identifier high register holds identifier bits 28 to 21.
// R12: Identifier mid register: bits 20-18, substitute remote bit, format flag, bits 17-15.
// R13: Format flag chooses 11-bit or 29-bit identifier; receive buffers store it as received.
// R14: Software sets the substitute remote bit in transmit buffers; receive stores it.
// R15: Each interrupt is raised only when its flag and its enable bit are set.
module crf_top (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire can_rx,
    input wire sleep_mode,
    input wire init_ack,
    input wire [7:0] rx_error_count,
    input wire [8:0] tx_error_count,
    input wire rx_frame_valid,
    input wire [28:0] rx_frame_id,
    input wire rx_frame_ide,
    input wire rx_frame_srr,
    input wire [4:0] arb_bit_index,
    input wire [28:0] peer_id,
    input wire peer_ide,
    output reg init_request,
    output reg wake_enable,
    output reg [1:0] rx_state_field,
    output reg [1:0] tx_state_field,
    output reg wake_irq,
    output reg error_irq,
    output reg irq,
    output reg arb_tx_bit,
    output reg arb_win
);

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    function crf_is_mapped;
        input [7:0] addr;
        begin
            case (addr)
                `CRF_OFF_FLAGS, `CRF_OFF_IEN, `CRF_OFF_CTL,
                `CRF_OFF_ID_HIGH, `CRF_OFF_ID_MID, `CRF_OFF_ID_LOW,
                `CRF_OFF_RX_HIGH, `CRF_OFF_RX_MID, `CRF_OFF_RX_LOW:
                    crf_is_mapped = 1'b1;
                default:
                    crf_is_mapped = 1'b0;
            endcase
        end
    endfunction

    // Bit idx counted from the start of the identifier, most significant first.
    function crf_msb_bit;
        input [28:0] value;
        input [4:0] len;
        input [4:0] idx;
        reg [4:0] pos;
        begin
            pos = len - 5'h01 - idx;
            if (idx < len)
                crf_msb_bit = value[pos];
            else
                crf_msb_bit = 1'b1;
        end
    endfunction

    // ------------------------------------------------------------------------
    // Input conditioning
    // ------------------------------------------------------------------------
    wire rx_sync;
    reg rx_prev;
    wire [3:0] calc_state;

    crf_sync #(
        .WIDTH(1),
        .RST_VALUE(1'b1)
    ) u_rx_sync (
        .pclk(pclk),
        .presetn(presetn),
        .async_in(can_rx),
        .sync_out(rx_sync)
    );

    crf_state_calc u_state (
        .pclk(pclk),
        .presetn(presetn),
        .rx_error_count(rx_error_count),
        .tx_error_count(tx_error_count),
        .calc_state(calc_state)
    );

    // ------------------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------------------
    // One wait state: pready is high in the second access cycle, and writes land on the edge that ends it.
    wire apb_access = psel & penable;
    wire apb_done = apb_access & pready;
    wire wr_en = apb_done & pwrite;
    wire init_active = init_request & init_ack;

    reg wake_flag;
    reg status_change_flag;
    reg [1:0] ien;
    reg [7:0] ext_id_high;
    reg [7:0] ext_id_mid;
    reg [14:0] ext_id_low;
    reg [7:0] rx_id_high;
    reg [7:0] rx_id_mid;
    reg [14:0] rx_id_low;

    wire wr_flags = wr_en & (paddr == `CRF_OFF_FLAGS) & ~init_active; // see R7
    wire clr_wake = wr_flags & pwdata[`CRF_FLG_WAKE]; // see R6
    wire clr_csc = wr_flags & pwdata[`CRF_FLG_CSC]; // see R6

    // ------------------------------------------------------------------------
    // Flag events
    // ------------------------------------------------------------------------
    // A falling edge on the synchronised line is the start of a dominant bit.
    wire bus_activity = rx_prev & ~rx_sync;
    wire wake_set = sleep_mode & wake_enable & bus_activity; // see R1
    wire [3:0] cur_state = {rx_state_field, tx_state_field};
    wire state_differs = (calc_state != cur_state);
    // A change seen while the flag stands is held off; it lands once software clears the flag.
    wire state_update = state_differs & ~status_change_flag; // see R3
    wire csc_set = state_update & ~init_active; // see R2

    reg next_wake_flag;
    reg next_csc_flag;

    always @* begin
        if (init_active) begin
            next_wake_flag = 1'b0; // see R7
            next_csc_flag = 1'b0; // see R7
        end else begin
            // Set wins over a clear arriving in the same cycle.
            next_wake_flag = wake_set | (wake_flag & ~clr_wake);
            next_csc_flag = csc_set | (status_change_flag & ~clr_csc);
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_prev <= 1'b1;
            wake_flag <= 1'b0;
            status_change_flag <= 1'b0;
            rx_state_field <= `CRF_ST_OK;
            tx_state_field <= `CRF_ST_OK;
        end else begin
            rx_prev <= rx_sync;
            wake_flag <= next_wake_flag;
            status_change_flag <= next_csc_flag;
            if (state_update) begin
                // Tracks the counters in and out of init mode alike.
                rx_state_field <= calc_state[3:2]; // see R8
                tx_state_field <= calc_state[1:0]; // see R4
            end
        end
    end

    // ------------------------------------------------------------------------
    // Software registers
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ien <= `CRF_IEN_RST;
            init_request <= 1'b0;
            wake_enable <= 1'b0;
            ext_id_high <= `CRF_ID_RST;
            ext_id_mid <= `CRF_ID_RST;
            ext_id_low <= `CRF_ID_LOW_RST;
        end else if (wr_en) begin
            case (paddr)
                `CRF_OFF_IEN: begin
                    ien <= {pwdata[`CRF_FLG_WAKE], pwdata[`CRF_FLG_CSC]};
                end
                `CRF_OFF_CTL: begin
                    init_request <= pwdata[`CRF_CTL_INIT];
                    wake_enable <= pwdata[`CRF_CTL_WAKE_EN];
                end
                `CRF_OFF_ID_HIGH: begin
                    ext_id_high <= pwdata[7:0]; // see R11
                end
                `CRF_OFF_ID_MID: begin
                    // Software is expected to write the substitute remote bit as one.
                    ext_id_mid <= pwdata[7:0]; // see R12 R14
                end
                `CRF_OFF_ID_LOW: begin
                    ext_id_low <= pwdata[14:0];
                end
                default: begin
                    ien <= ien;
                end
            endcase
        end
    end

    // ------------------------------------------------------------------------
    // Receive identifier buffer
    // ------------------------------------------------------------------------
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_id_high <= `CRF_ID_RST;
            rx_id_mid <= `CRF_ID_RST;
            rx_id_low <= `CRF_ID_LOW_RST;
        end else if (rx_frame_valid) begin
            if (rx_frame_ide) begin
                rx_id_high <= rx_frame_id[28:21]; // see R11
                // Format and substitute remote bits are kept as they came off the bus.
                rx_id_mid <= {rx_frame_id[20:18], rx_frame_srr, 1'b1, rx_frame_id[17:15]}; // see R12 R13 R14
                rx_id_low <= rx_frame_id[14:0];
            end else begin
                rx_id_high <= rx_frame_id[10:3]; // see R13
                rx_id_mid <= {rx_frame_id[2:0], 5'h00};
                rx_id_low <= `CRF_ID_LOW_RST;
            end
        end
    end

    // ------------------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------------------
    wire tx_ide = ext_id_mid[`CRF_IDM_IDE];
    wire [28:0] tx_id_ext = {ext_id_high, ext_id_mid[7:5], ext_id_mid[2:0], ext_id_low}; // see R9
    wire [28:0] tx_id_std = {18'h00000, ext_id_high, ext_id_mid[7:5]};
    wire [10:0] my_base = tx_ide ? tx_id_ext[28:18] : tx_id_std[10:0];
    wire [10:0] peer_base = peer_ide ? peer_id[28:18] : peer_id[10:0];
    // On equal base identifiers the standard frame wins, its format bit being dominant.
    wire base_tie_win = tx_ide ? (peer_ide & (tx_id_ext[17:0] < peer_id[17:0])) : peer_ide;
    wire next_arb_win = (my_base < peer_base) | ((my_base == peer_base) & base_tie_win); // see R10
    wire next_arb_bit = tx_ide ? crf_msb_bit(tx_id_ext, 5'h1D, arb_bit_index)
                               : crf_msb_bit(tx_id_std, 5'h0B, arb_bit_index); // see R9 R13

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            arb_tx_bit <= 1'b1;
            arb_win <= 1'b0;
        end else begin
            arb_tx_bit <= next_arb_bit;
            arb_win <= next_arb_win;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------------
    // Outputs follow the flags with one cycle of latency so that they come from flip-flops.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wake_irq <= 1'b0;
            error_irq <= 1'b0;
            irq <= 1'b0;
        end else begin
            wake_irq <= wake_flag & ien[1]; // see R1 R15
            error_irq <= status_change_flag & ien[0]; // see R2 R15
            irq <= (wake_flag & ien[1]) | (status_change_flag & ien[0]); // see R15
        end
    end

    // ------------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------------
    reg [31:0] read_word;

    always @* begin
        read_word = 32'h00000000;
        case (paddr)
            `CRF_OFF_FLAGS: begin
                read_word[7:0] = {wake_flag, status_change_flag, rx_state_field, tx_state_field, 2'h0};
            end
            `CRF_OFF_IEN: begin
                read_word[7:0] = {ien, 6'h00};
            end
            `CRF_OFF_CTL: begin
                read_word[2:0] = {init_ack, wake_enable, init_request};
            end
            `CRF_OFF_ID_HIGH: begin
                read_word[7:0] = ext_id_high;
            end
            `CRF_OFF_ID_MID: begin
                read_word[7:0] = ext_id_mid;
            end
            `CRF_OFF_ID_LOW: begin
                read_word[14:0] = ext_id_low;
            end
            `CRF_OFF_RX_HIGH: begin
                read_word[7:0] = rx_id_high;
            end
            `CRF_OFF_RX_MID: begin
                read_word[7:0] = rx_id_mid;
            end
            `CRF_OFF_RX_LOW: begin
                read_word[14:0] = rx_id_low;
            end
            default: begin
                read_word = 32'h00000000;
            end
        endcase
    end

    // The answer always comes one cycle into the access phase, so a master never waits longer.
    // Unmapped offsets answer with an error and read as zero; the read-only receive copies
    // ignore writes quietly, so software may sweep the whole map without tripping an error.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (apb_access & ~pready) begin
            pready <= 1'b1;
            pslverr <= ~crf_is_mapped(paddr);
            prdata <= pwrite ? 32'h00000000 : read_word;
        end else begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end
    end

endmodule

`default_nettype wire

// ===== verilog/crf_regs.vh
// Register offsets, field positions, reset values and limits of the CAN receiver flag block.
`ifndef CRF_REGS_VH
`define CRF_REGS_VH

// ----------------------------------------------------------------------------
// Byte offsets on the APB register bus
// ----------------------------------------------------------------------------
`define CRF_OFF_FLAGS 8'h00
`define CRF_OFF_IEN 8'h04
`define CRF_OFF_CTL 8'h08
`define CRF_OFF_ID_HIGH 8'h0C
`define CRF_OFF_ID_MID 8'h10
`define CRF_OFF_ID_LOW 8'h14
`define CRF_OFF_RX_HIGH 8'h18
`define CRF_OFF_RX_MID 8'h1C
`define CRF_OFF_RX_LOW 8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define CRF_FLG_WAKE 7
`define CRF_FLG_CSC 6
`define CRF_FLG_RX_HI 5
`define CRF_FLG_RX_LO 4
`define CRF_FLG_TX_HI 3
`define CRF_FLG_TX_LO 2
`define CRF_CTL_INIT 0
`define CRF_CTL_WAKE_EN 1
`define CRF_CTL_INIT_ACK 2
`define CRF_IDM_SRR 4
`define CRF_IDM_IDE 3

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define CRF_FLAGS_RST 2'h0
`define CRF_IEN_RST 2'h0
`define CRF_CTL_RST 2'h0
`define CRF_STATE_RST 4'h0
`define CRF_ID_RST 8'h00
`define CRF_ID_LOW_RST 15'h0000

// ----------------------------------------------------------------------------
// Error counter limits and state codes
// ----------------------------------------------------------------------------
`define CRF_WARN_LIMIT 9'h060
`define CRF_ERR_LIMIT 9'h080
`define CRF_BUSOFF_LIMIT 9'h100
`define CRF_ST_OK 2'h0
`define CRF_ST_WARN 2'h1
`define CRF_ST_ERR 2'h2
`define CRF_ST_BUSOFF 2'h3

`endif

// ===== verilog/crf_sync.v
// Two flip-flop synchroniser for levels arriving from outside the pclk domain.
`timescale 1ns/1ps
`default_nettype none

module crf_sync #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RST_VALUE = {WIDTH{1'b1}}
) (
    input wire pclk,
    input wire presetn,
    input wire [WIDTH-1:0] async_in,
    output reg [WIDTH-1:0] sync_out
);

    reg [WIDTH-1:0] meta;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta <= RST_VALUE;
            sync_out <= RST_VALUE;
        end else begin
            meta <= async_in;
            sync_out <= meta;
        end
    end

endmodule

`default_nettype wire

// ===== verilog/crf_state_calc.v
// Registered translation of the error counters into the receiver and transmitter state codes.
`timescale 1ns/1ps
`default_nettype none
`include "crf_regs.vh"

module crf_state_calc (
    input wire pclk,
    input wire presetn,
    input wire [7:0] rx_error_count,
    input wire [8:0] tx_error_count,
    output reg [3:0] calc_state
);

    function [1:0] crf_level;
        input [8:0] count;
        begin
            if (count < `CRF_WARN_LIMIT)
                crf_level = `CRF_ST_OK;
            else if (count < `CRF_ERR_LIMIT)
                crf_level = `CRF_ST_WARN;
            else
                crf_level = `CRF_ST_ERR;
        end
    endfunction

    wire bus_off = (tx_error_count >= `CRF_BUSOFF_LIMIT);
    wire [1:0] rx_code = bus_off ? `CRF_ST_BUSOFF : crf_level({1'b0, rx_error_count}); // see R5
    wire [1:0] tx_code = bus_off ? `CRF_ST_BUSOFF : crf_level(tx_error_count);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            calc_state <= `CRF_STATE_RST;
        end else begin
            calc_state <= {rx_code, tx_code}; // see R4
        end
    end

endmodule

`default_nettype wire

// ===== sim/crf_top_chk.sv
// Port-level assertion checker for the CAN receiver flag block.
`timescale 1ns/1ps
`default_nettype none
module crf_top_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic init_ack,
    input wire logic init_request,
    input wire logic wake_enable,
    input wire logic [1:0] rx_state_field,
    input wire logic [1:0] tx_state_field,
    input wire logic wake_irq,
    input wire logic error_irq,
    input wire logic irq,
    input wire logic [4:0] arb_bit_index,
    input wire logic arb_tx_bit
);
    // ------------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    pready_one_a: assert property (pready |=> !pready) else $error("pready held too long");
    pready_wait_a: assert property (psel && !penable |-> ##2 pready) else $error("pready not in access cycle two");
    slverr_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h20))
        else $error("pslverr does not match address map");
    rdata_idle_a: assert property (!pready |-> prdata == 32'h0) else $error("read data outside answer");
    irq_or_a: assert property (irq == (wake_irq || error_irq)) else $error("irq not or of requests");
    state_hold_a: assert property (error_irq && $past(error_irq) |-> $stable(rx_state_field) && $stable(tx_state_field))
        else $error("state moved while change flag pending");
    init_quiet_a: assert property ((init_request && init_ack) [*2] |=> !wake_irq && !error_irq)
        else $error("request during init mode");
    ctl_write_a: assert property (psel && penable && pready && pwrite && paddr == 8'h08
        |=> {wake_enable, init_request} == $past(pwdata[1:0])) else $error("control bits not written");
    arb_pad_a: assert property ($past(arb_bit_index) > 5'h1C |-> arb_tx_bit)
        else $error("bit beyond identifier not recessive");
endmodule
bind crf_top crf_top_chk i_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .init_ack(init_ack),
    .init_request(init_request), .wake_enable(wake_enable), .rx_state_field(rx_state_field),
    .tx_state_field(tx_state_field), .wake_irq(wake_irq), .error_irq(error_irq), .irq(irq),
    .arb_bit_index(arb_bit_index), .arb_tx_bit(arb_tx_bit));
`default_nettype wire

// ===== sim/crf_can_node.sv
// Behavioural model of another node on the CAN bus.
`timescale 1ns/1ps
`default_nettype none
module crf_can_node (
    input wire logic pclk,
    output logic can_rx,
    output logic [28:0] peer_id,
    output logic peer_ide
);
    initial begin
        can_rx = 1'b1;
        peer_id = 29'h1FFFFFFF;
        peer_ide = 1'b1;
    end
    // A dominant burst; the line then returns recessive, as a released CAN line does.
    task automatic burst(input int n);
        @(posedge pclk);
        can_rx <= 1'b0;
        repeat (n) @(posedge pclk);
        can_rx <= 1'b1;
    endtask
    task automatic compete(input logic [28:0] id);
        @(posedge pclk);
        peer_id <= id;
    endtask
endmodule
`default_nettype wire

// ===== sim/testbench.sv
// Self-checking testbench for the CAN receiver flag block.
`timescale 1ns/1ps
`default_nettype none
`include "crf_regs.vh"
module testbench;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pslverr, pready, er;
    logic [7:0] paddr = 0, rx_error_count = 0;
    logic [8:0] tx_error_count = 0;
    logic [31:0] pwdata = 0, prdata, rd;
    logic sleep_mode = 0, init_ack = 0, rx_frame_valid = 0, rx_frame_ide = 0, rx_frame_srr = 0, can_rx, peer_ide;
    logic [28:0] rx_frame_id = 0, peer_id;
    logic [4:0] arb_bit_index = 0;
    logic init_request, wake_enable, wake_irq, error_irq, irq, arb_tx_bit, arb_win;
    logic [1:0] rx_state_field, tx_state_field;
    int miscompares = 0, n_tests = 0;
    always #50 pclk = ~pclk;
    crf_can_node i_node (.pclk(pclk), .can_rx(can_rx), .peer_id(peer_id), .peer_ide(peer_ide));
    crf_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .can_rx(can_rx),
        .sleep_mode(sleep_mode), .init_ack(init_ack), .rx_error_count(rx_error_count),
        .tx_error_count(tx_error_count), .rx_frame_valid(rx_frame_valid), .rx_frame_id(rx_frame_id),
        .rx_frame_ide(rx_frame_ide), .rx_frame_srr(rx_frame_srr), .arb_bit_index(arb_bit_index),
        .peer_id(peer_id), .peer_ide(peer_ide), .init_request(init_request), .wake_enable(wake_enable),
        .rx_state_field(rx_state_field), .tx_state_field(tx_state_field), .wake_irq(wake_irq),
        .error_irq(error_irq), .irq(irq), .arb_tx_bit(arb_tx_bit), .arb_win(arb_win));
    // ------------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            miscompares++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
        #10;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1;
        penable <= 0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        chk(n, 2);
        psel <= 0;
        penable <= 0;
    endtask
    task automatic cnt(input logic [7:0] r, input logic [8:0] t);
        @(posedge pclk);
        rx_error_count <= r;
        tx_error_count <= t;
        wt(4);
    endtask
    function automatic logic [1:0] lvl(input int c);
        return (c >= 128) ? 2'h2 : (c >= 96) ? 2'h1 : 2'h0;
    endfunction
    // ------------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------------
    task automatic t_regs;
        apb(0, `CRF_OFF_FLAGS, 0);
        chk(rd, 0);
        apb(1, 8'h24, 32'hFF);
        chk(er, 1);
        apb(0, 8'h24, 0);
        chk({er, rd[30:0]}, 32'h80000000);
    endtask
    task automatic t_codes;
        int rs[7] = '{95, 96, 127, 128, 0, 0, 0};
        int ts[7] = '{0, 0, 95, 96, 128, 256, 0};
        logic [3:0] e, old;
        old = 0;
        for (int i = 0; i < 7; i++) begin
            cnt(rs[i], ts[i]);
            e = (ts[i] >= 256) ? 4'hF : {lvl(rs[i]), lvl(ts[i])};
            chk({rx_state_field, tx_state_field}, e);
            apb(1, `CRF_OFF_FLAGS, 32'h3C);
            apb(0, `CRF_OFF_FLAGS, 0);
            chk(rd, {25'h0, e != old, e, 2'h0});
            apb(1, `CRF_OFF_FLAGS, 32'h40);
            apb(0, `CRF_OFF_FLAGS, 0);
            chk(rd, {26'h0, e, 2'h0});
            old = e;
        end
    endtask
    task automatic t_block;
        apb(1, `CRF_OFF_IEN, 32'h40);
        cnt(96, 0);
        chk({error_irq, irq}, 2'h3);
        cnt(128, 0);
        chk(rx_state_field, 1);
        apb(1, `CRF_OFF_FLAGS, 32'h40);
        wt(4);
        apb(0, `CRF_OFF_FLAGS, 0);
        chk(rd, 32'h60);
        apb(1, `CRF_OFF_IEN, 0);
        wt(2);
        chk(error_irq, 0);
        apb(1, `CRF_OFF_FLAGS, 32'h40);
        cnt(0, 0);
        apb(1, `CRF_OFF_FLAGS, 32'h40);
    endtask
    task automatic t_wake;
        apb(1, `CRF_OFF_IEN, 32'h80);
        apb(1, `CRF_OFF_CTL, 32'h02);
        i_node.burst(4);
        wt(6);
        chk(wake_irq, 0);
        @(posedge pclk);
        sleep_mode <= 1;
        i_node.burst(4);
        wt(6);
        chk({wake_irq, irq}, 2'h3);
        apb(0, `CRF_OFF_FLAGS, 0);
        chk(rd, 32'h80);
        apb(1, `CRF_OFF_FLAGS, 32'h80);
        wt(2);
        chk(irq, 0);
    endtask
    task automatic t_init;
        i_node.burst(4);
        wt(6);
        apb(1, `CRF_OFF_CTL, 32'h03);
        init_ack <= 1;
        cnt(100, 0);
        apb(0, `CRF_OFF_CTL, 0);
        chk(rd, 32'h07);
        apb(0, `CRF_OFF_FLAGS, 0);
        chk(rd, 32'h10);
        chk({irq, rx_state_field}, 3'h1);
        @(posedge pclk);
        init_ack <= 0;
        apb(1, `CRF_OFF_CTL, 0);
        cnt(0, 0);
        apb(0, `CRF_OFF_FLAGS, 0);
        chk(rd, 32'h40);
        apb(1, `CRF_OFF_FLAGS, 32'h40);
    endtask
    task automatic t_id;
        logic [28:0] id;
        id = 29'h12345678;
        apb(1, `CRF_OFF_ID_HIGH, {24'h0, id[28:21]});
        apb(1, `CRF_OFF_ID_MID, {24'h0, id[20:18], 2'h3, id[17:15]});
        apb(1, `CRF_OFF_ID_LOW, {17'h0, id[14:0]});
        apb(0, `CRF_OFF_ID_MID, 0);
        chk(rd, {24'h0, id[20:18], 2'h3, id[17:15]});
        for (int i = 0; i < 32; i++) begin
            @(posedge pclk);
            arb_bit_index <= i[4:0];
            wt(2);
            chk(arb_tx_bit, (i < 29) ? id[28 - i] : 1'b1);
        end
        i_node.compete(id + 29'h1);
        wt(2);
        chk(arb_win, 1);
        i_node.compete(id - 29'h1);
        wt(2);
        chk(arb_win, 0);
        apb(1, `CRF_OFF_ID_MID, {24'h0, id[20:18], 5'h10});
        @(posedge pclk);
        arb_bit_index <= 5'h0A;
        wt(2);
        chk(arb_win, 1);
        chk(arb_tx_bit, id[18]);
        for (int k = 0; k < 2; k++) begin
            @(posedge pclk);
            rx_frame_valid <= 1;
            rx_frame_id <= ~id;
            rx_frame_ide <= (k == 0);
            rx_frame_srr <= 1;
            @(posedge pclk);
            rx_frame_valid <= 0;
            apb(0, `CRF_OFF_RX_MID, 0);
            chk(rd, (k == 0) ? {24'h0, ~id[20:18], 2'h3, ~id[17:15]} : {24'h0, ~id[2:0], 5'h0});
            apb(0, `CRF_OFF_RX_HIGH, 0);
            chk(rd, (k == 0) ? {24'h0, ~id[28:21]} : {24'h0, ~id[10:3]});
        end
    endtask
    task automatic end_of_test;
        if (miscompares == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    initial begin
        #1000000;
        miscompares++;
        end_of_test;
    end
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1;
        t_regs;
        t_codes;
        t_block;
        t_wake;
        t_init;
        t_id;
        end_of_test;
    end
endmodule
`default_nettype wire
